//--- src/cc_defs.vh
`ifndef CC_DEFS_VH
`define CC_DEFS_VH

// register byte offsets, decoded on haddr[7:0]
`define OFS_UNIT_CONTROL     8'h00
`define OFS_MATCH_LOW        8'h04
`define OFS_MATCH_HIGH       8'h08
`define OFS_TIMER_LOW        8'h0C
`define OFS_TIMER_HIGH       8'h10
`define OFS_TIMER_CONFIG     8'h14
`define OFS_STATUS           8'h18

// reset values
`define CTRL_RESET           8'h00
`define MATCH_RESET          8'h00
`define CONFIG_RESET         8'h08

// unit_mode_field encodings
`define MODE_OFF             4'h0
`define MODE_TOGGLE          4'h2
`define MODE_CAP_FALL        4'h4
`define MODE_CAP_RISE        4'h5
`define MODE_CAP_RISE4       4'h6
`define MODE_CAP_RISE16      4'h7
`define MODE_CMP_SET         4'h8
`define MODE_CMP_CLEAR       4'h9
`define MODE_SW_INT          4'hA
`define MODE_SPECIAL         4'hB

// field positions
`define MODE_MSB             3
`define MODE_LSB             0
`define CFG_SRC_MSB          1
`define CFG_SRC_LSB          0
`define CFG_ON_BIT           2
`define CFG_DIR_BIT          3
`define ST_EVENT_BIT         0
`define ST_OVF_BIT           1

// timer clock sources
`define SRC_INSTR            2'h0
`define SRC_SYS              2'h1
`define SRC_EXT              2'h2

// timing counts and the AHB word transfer size
`define INSTR_LAST           2'h3
`define CAP_LAST4            4'h3
`define CAP_LAST16           4'hF
`define AHB_WORD             3'h2

`endif

//--- src/cap_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "cc_defs.vh"

module cap_prescaler (
  input  wire       clk,
  input  wire       rst,
  input  wire       pin_level,
  input  wire [3:0] mode,
  output reg        capture_evt
);

  reg        prev_r;
  reg  [3:0] cnt_r;

  wire       rise = pin_level & ~prev_r;
  wire       fall = ~pin_level & prev_r;
  wire       is_cap = (mode[3:2] == 2'h1);

  // count rising edges; at or past the last count an event fires
  function [4:0] step;
    input [3:0] cnt;
    input [3:0] last;
    begin
      if (cnt >= last) begin
        step = 5'h10;
      end else begin
        step = {1'b0, cnt + 4'h1};
      end
    end
  endfunction

  wire [4:0] step4  = step(cnt_r, `CAP_LAST4);
  wire [4:0] step16 = step(cnt_r, `CAP_LAST16);

  always @(posedge clk) begin
    if (rst) begin
      prev_r      <= 1'b0;
      cnt_r       <= 4'h0;
      capture_evt <= 1'b0;
    end else begin
      prev_r      <= pin_level;
      capture_evt <= 1'b0;
      if (!is_cap) begin
        cnt_r <= 4'h0;
      end else begin
        case (mode)
          `MODE_CAP_FALL: begin
            capture_evt <= fall;
          end
          `MODE_CAP_RISE: begin
            capture_evt <= rise;
          end
          `MODE_CAP_RISE4: begin
            if (rise) begin
              cnt_r       <= step4[3:0];
              capture_evt <= step4[4];
            end
          end
          default: begin
            if (rise) begin
              cnt_r       <= step16[3:0];
              capture_evt <= step16[4];
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- src/timer16.v
`timescale 1ns/1ps
`default_nettype none
`include "cc_defs.vh"

module timer16 (
  input  wire        clk,
  input  wire        rst,
  input  wire        run,
  input  wire [1:0]  src,
  input  wire        sleep,
  input  wire        ext_rise,
  input  wire        clear_req,
  input  wire        wr_lo,
  input  wire        wr_hi,
  input  wire [7:0]  wdata,
  output reg  [15:0] count,
  output reg         tick,
  output reg         ovf_pulse
);

  reg  [1:0] div_r;
  reg        adv;

  wire       instr_en = (div_r == `INSTR_LAST);

  always @* begin
    case (src)
      `SRC_SYS:   adv = run & ~sleep;
      `SRC_INSTR: adv = run & ~sleep & instr_en;
      `SRC_EXT:   adv = run & ext_rise;
      default:    adv = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      div_r     <= 2'h0;
      count     <= 16'h0000;
      tick      <= 1'b0;
      ovf_pulse <= 1'b0;
    end else begin
      if (!sleep) begin
        div_r <= div_r + 2'h1;
      end
      tick      <= 1'b0;
      ovf_pulse <= 1'b0;
      if (wr_lo || wr_hi) begin
        if (wr_lo) begin
          count[7:0] <= wdata;
        end
        if (wr_hi) begin
          count[15:8] <= wdata;
        end
      end else if (adv) begin
        tick <= 1'b1;
        if (clear_req) begin
          count <= 16'h0000;
        end else begin
          count <= count + 16'h0001;
          ovf_pulse <= (count == 16'hFFFF);
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- src/capture_compare_top.v
`timescale 1ns/1ps
`default_nettype none
`include "cc_defs.vh"

module capture_compare_top (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        unit_pin_in,
  output reg         unit_pin_out,
  output reg         unit_pin_oe_n,
  input  wire        ext_timer_clk,
  input  wire        sleep_req,
  input  wire        adc_enable,
  output reg         adc_start,
  output reg         unit_event_flag,
  output reg         timer_overflow_flag
);

  // bus data phase state
  reg        dph_r;
  reg        dwr_r;
  reg        dok_r;
  reg  [7:0] daddr_r;

  // software registers
  reg  [7:0] unit_control_r;
  reg  [7:0] match_value_low_r;
  reg  [7:0] match_value_high_r;
  reg  [7:0] timer_config_r;

  // compare state
  reg        cmp_latch_r;
  reg        pend_reset_r;

  // pin synchronisers
  reg        pin_s1_r;
  reg        pin_s2_r;
  reg        ext_s1_r;
  reg        ext_s2_r;
  reg        ext_s3_r;

  reg  [31:0] rd_nxt;

  wire [15:0] timer_count;
  wire        timer_tick;
  wire        timer_ovf;
  wire        capture_evt;

  wire [3:0]  unit_mode_field = unit_control_r[`MODE_MSB:`MODE_LSB];
  wire [15:0] match_pair = {match_value_high_r, match_value_low_r};
  wire        pin_direction_bit = timer_config_r[`CFG_DIR_BIT];

  function is_compare;
    input [3:0] m;
    begin
      is_compare = (m == `MODE_TOGGLE) || (m == `MODE_CMP_SET) ||
                   (m == `MODE_CMP_CLEAR) || (m == `MODE_SW_INT) ||
                   (m == `MODE_SPECIAL);
    end
  endfunction

  function drives_pin;
    input [3:0] m;
    begin
      drives_pin = (m == `MODE_TOGGLE) || (m == `MODE_CMP_SET) ||
                   (m == `MODE_CMP_CLEAR);
    end
  endfunction

  // accepted transfer and write strobes
  wire accept = hsel & hready & htrans[1];
  wire wr_go  = dph_r & dwr_r & dok_r;

  function wr_at;
    input       go;
    input [7:0] a;
    input [7:0] ofs;
    begin
      wr_at = go && (a == ofs);
    end
  endfunction

  wire wr_ctrl   = wr_at(wr_go, daddr_r, `OFS_UNIT_CONTROL);
  wire wr_mlo    = wr_at(wr_go, daddr_r, `OFS_MATCH_LOW);
  wire wr_mhi    = wr_at(wr_go, daddr_r, `OFS_MATCH_HIGH);
  wire wr_tlo    = wr_at(wr_go, daddr_r, `OFS_TIMER_LOW);
  wire wr_thi    = wr_at(wr_go, daddr_r, `OFS_TIMER_HIGH);
  wire wr_cfg    = wr_at(wr_go, daddr_r, `OFS_TIMER_CONFIG);
  wire wr_status = wr_at(wr_go, daddr_r, `OFS_STATUS);

  wire equal = (timer_count == match_pair);

  wire match_hit = timer_tick & equal & is_compare(unit_mode_field) & ~sleep_req;

  wire hit_special = match_hit & (unit_mode_field == `MODE_SPECIAL);

  wire clear_req = pend_reset_r & equal & (unit_mode_field == `MODE_SPECIAL);

  wire ext_rise = ext_s2_r & ~ext_s3_r;

  wire event_set = match_hit | capture_evt;
  wire event_clr = wr_status & hwdata[`ST_EVENT_BIT];
  wire ovf_clr   = wr_status & hwdata[`ST_OVF_BIT];

  timer16 u_timer (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .run       (timer_config_r[`CFG_ON_BIT]),
    .src       (timer_config_r[`CFG_SRC_MSB:`CFG_SRC_LSB]),
    .sleep     (sleep_req),
    .ext_rise  (ext_rise),
    .clear_req (clear_req),
    .wr_lo     (wr_tlo),
    .wr_hi     (wr_thi),
    .wdata     (hwdata[7:0]),
    .count     (timer_count),
    .tick      (timer_tick),
    .ovf_pulse (timer_ovf)
  );

  // capture runs on sys_clk, so sleep does not gate it
  cap_prescaler u_capture (
    .clk         (sys_clk),
    .rst         (sys_rst),
    .pin_level   (pin_s2_r),
    .mode        (unit_mode_field),
    .capture_evt (capture_evt)
  );

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= unit_pin_in;
      pin_s2_r <= pin_s1_r;
      ext_s1_r <= ext_timer_clk;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // one wait state: write data and read mux settle in the cycle hready is low
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      dph_r     <= 1'b0;
      dwr_r     <= 1'b0;
      dok_r     <= 1'b0;
      daddr_r   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (accept) begin
        dph_r     <= 1'b1;
        dwr_r     <= hwrite;
        dok_r     <= (hsize == `AHB_WORD);
        daddr_r   <= haddr[7:0];
        hreadyout <= 1'b0;
      end else if (dph_r) begin
        dph_r     <= 1'b0;
        hreadyout <= 1'b1;
        if (!dwr_r) begin
          hrdata <= rd_nxt;
        end
      end
    end
  end

  always @* begin
    rd_nxt = 32'h00000000;
    case (daddr_r)
      `OFS_UNIT_CONTROL: rd_nxt[7:0] = unit_control_r;
      `OFS_MATCH_LOW:    rd_nxt[7:0] = match_value_low_r;
      `OFS_MATCH_HIGH:   rd_nxt[7:0] = match_value_high_r;
      `OFS_TIMER_LOW:    rd_nxt[7:0] = timer_count[7:0];
      `OFS_TIMER_HIGH:   rd_nxt[7:0] = timer_count[15:8];
      `OFS_TIMER_CONFIG: rd_nxt[7:0] = timer_config_r;
      `OFS_STATUS: begin
        rd_nxt[`ST_EVENT_BIT] = unit_event_flag;
        rd_nxt[`ST_OVF_BIT]   = timer_overflow_flag;
      end
      default:           rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      unit_control_r <= `CTRL_RESET;
      timer_config_r <= `CONFIG_RESET;
    end else begin
      if (wr_ctrl) begin
        unit_control_r <= hwdata[7:0];
      end
      if (wr_cfg) begin
        timer_config_r <= hwdata[7:0];
      end
    end
  end

  // a capture overrides a software write in the same cycle
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      match_value_low_r  <= `MATCH_RESET;
      match_value_high_r <= `MATCH_RESET;
    end else if (capture_evt) begin
      match_value_low_r  <= timer_count[7:0];
      match_value_high_r <= timer_count[15:8];
    end else begin
      if (wr_mlo) begin
        match_value_low_r <= hwdata[7:0];
      end
      if (wr_mhi) begin
        match_value_high_r <= hwdata[7:0];
      end
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cmp_latch_r  <= 1'b0;
      pend_reset_r <= 1'b0;
      adc_start    <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      if (wr_ctrl && (hwdata[7:0] == 8'h00)) begin
        cmp_latch_r <= 1'b0;
      end else if (match_hit) begin
        case (unit_mode_field)
          `MODE_TOGGLE:    cmp_latch_r <= ~cmp_latch_r;
          `MODE_CMP_SET:   cmp_latch_r <= 1'b1;
          `MODE_CMP_CLEAR: cmp_latch_r <= 1'b0;
          default:         cmp_latch_r <= cmp_latch_r;
        endcase
      end
      if (hit_special) begin
        adc_start <= adc_enable;
      end
      pend_reset_r <= hit_special | clear_req;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      unit_event_flag     <= 1'b0;
      timer_overflow_flag <= 1'b0;
    end else begin
      unit_event_flag     <= event_set | (unit_event_flag & ~event_clr);
      timer_overflow_flag <= timer_ovf | (timer_overflow_flag & ~ovf_clr);
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      unit_pin_out  <= 1'b0;
      unit_pin_oe_n <= 1'b1;
    end else begin
      unit_pin_out  <= cmp_latch_r;
      unit_pin_oe_n <= pin_direction_bit | ~drives_pin(unit_mode_field);
    end
  end

endmodule
`default_nettype wire

//--- testbench/cc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cc_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        unit_pin_out,
  input wire logic        unit_pin_oe_n,
  input wire logic        adc_enable,
  input wire logic        adc_start,
  input wire logic        unit_event_flag,
  input wire logic        timer_overflow_flag
);
  logic acc;
  logic wr0_q;
  logic wst_q;
  assign acc = hsel && hready && htrans[1];
  // data phase markers: control write, status write
  always @(posedge sys_clk) begin
    wr0_q <= acc && hwrite && (hsize == 3'h2) && (haddr[7:0] == 8'h00);
    wst_q <= acc && hwrite && (haddr[7:0] == 8'h18);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  bus_wait_state_a: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take exactly one wait state");
  zero_ctrl_a: assert property (wr0_q && hwdata[7:0] == 8'h00 |-> ##[2:3] (!unit_pin_out && unit_pin_oe_n))
    else $error("zero control write left pin latch or driver on");
  trig_pin_free_a: assert property (adc_start |-> unit_pin_oe_n)
    else $error("pin driven in trigger mode");
  trig_adc_gate_a: assert property (adc_start |-> $past(adc_enable))
    else $error("conversion start with converter disabled");
  trig_sets_flag_a: assert property (adc_start |-> unit_event_flag)
    else $error("trigger without event flag");
  single_match_a: assert property (adc_start |=> !adc_start)
    else $error("trigger held for more than one cycle");
  no_ovf_trig_a: assert property (adc_start |=> (!$rose(timer_overflow_flag))[*6])
    else $error("trigger reset raised overflow flag");
  flag_sticky_a: assert property ($fell(unit_event_flag) |-> $past(wst_q))
    else $error("event flag dropped without status write");
  cover property (adc_start);
  cover property (!unit_pin_oe_n);
  cover property ($rose(unit_event_flag));
  cover property (wr0_q);
endmodule
bind capture_compare_top cc_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n), .adc_enable(adc_enable), .adc_start(adc_start),
  .unit_event_flag(unit_event_flag), .timer_overflow_flag(timer_overflow_flag));
`default_nettype wire

//--- testbench/pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic sys_clk,
  input wire logic adc_start,
  output var logic unit_pin_in,
  output var logic ext_timer_clk
);
  int n_adc = 0;
  initial begin
    unit_pin_in = 1'h0;
    ext_timer_clk = 1'h0;
  end
  // converter side only counts starts
  always @(posedge sys_clk) begin
    if (adc_start === 1'h1) begin
      n_adc <= n_adc + 1;
    end
  end
  // levels change just after an edge, so the synchroniser never races the clock
  task pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      unit_pin_in <= 1'h1;
      repeat (4) @(posedge sys_clk);
      unit_pin_in <= 1'h0;
    end
    repeat (6) @(posedge sys_clk);
  endtask
  task ext_edges(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      ext_timer_clk <= 1'h1;
      repeat (4) @(posedge sys_clk);
      ext_timer_clk <= 1'h0;
    end
    repeat (6) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- testbench/timer_capture_compare_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cc_defs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module timer_capture_compare_unit_bench;
  logic        sys_clk, sys_rst, hsel, hwrite, sleep_req, adc_enable;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, unit_pin_in, unit_pin_out, unit_pin_oe_n;
  logic        ext_timer_clk, adc_start, unit_event_flag, timer_overflow_flag;
  int          n_errors = 0;
  int          check_count = 0;
  logic [7:0]  ro [8] = '{`OFS_UNIT_CONTROL, `OFS_MATCH_LOW, `OFS_MATCH_HIGH, `OFS_TIMER_LOW,
                          `OFS_TIMER_HIGH, `OFS_TIMER_CONFIG, `OFS_STATUS, 8'h1C};
  logic [7:0]  rv [8] = '{`CTRL_RESET, `MATCH_RESET, `MATCH_RESET, 8'h00, 8'h00, `CONFIG_RESET, 8'h00, 8'h00};
  logic [3:0]  cm [5] = '{`MODE_CMP_SET, `MODE_CMP_CLEAR, `MODE_TOGGLE, `MODE_SW_INT, `MODE_SPECIAL};
  logic        co [5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
  logic        cp [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
  int          pn [4] = '{1, 1, 4, 16};

  capture_compare_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .unit_pin_in(unit_pin_in), .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n),
    .ext_timer_clk(ext_timer_clk), .sleep_req(sleep_req), .adc_enable(adc_enable), .adc_start(adc_start),
    .unit_event_flag(unit_event_flag), .timer_overflow_flag(timer_overflow_flag));
  pin_source fe (.sys_clk(sys_clk), .adc_start(adc_start), .unit_pin_in(unit_pin_in),
    .ext_timer_clk(ext_timer_clk));

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= `AHB_WORD;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    q = hrdata;
    `CHK(hresp, 1'h0)
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task rd(input logic [7:0] a);
    xfer(1'h0, a, 32'h0);
  endtask
  task wait_flag;
    for (int i = 0; i < 300; i++) if (unit_event_flag !== 1'h1) @(posedge sys_clk);
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    print_verdict;
  end

  initial begin
    {sys_rst, hsel, hwrite, sleep_req, adc_enable} = 5'h10;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, `AHB_WORD};
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      rd(ro[i]);
      `CHK(q, {24'h0, rv[i]})
    end
    wr(`OFS_MATCH_LOW, 32'h10);
    wr(`OFS_MATCH_HIGH, 32'h0);
    wr(`OFS_TIMER_CONFIG, 32'h04);
    adc_enable <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_STATUS, 32'h3);
      wr(`OFS_TIMER_LOW, 32'h0);
      wr(`OFS_TIMER_HIGH, 32'h0);
      wr(`OFS_UNIT_CONTROL, {28'h0, cm[i]});
      wait_flag;
      repeat (3) @(posedge sys_clk);
      `CHK(unit_event_flag, 1'h1)
      `CHK(unit_pin_oe_n, co[i])
      if (!co[i]) `CHK(unit_pin_out, cp[i])
    end
    rd(`OFS_TIMER_LOW);
    `CHK(q < 32'h10, 1'h1)
    `CHK(fe.n_adc, 1)
    `CHK(timer_overflow_flag, 1'h0)
    wr(`OFS_UNIT_CONTROL, 32'h0);
    repeat (3) @(posedge sys_clk);
    `CHK({unit_pin_out, unit_pin_oe_n}, 2'h1)
    wr(`OFS_TIMER_CONFIG, 32'h08);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_UNIT_CONTROL, 32'h0);
      wr(`OFS_STATUS, 32'h3);
      wr(`OFS_TIMER_LOW, 32'h34 + i);
      wr(`OFS_TIMER_HIGH, 32'h12 + i);
      wr(`OFS_UNIT_CONTROL, 32'h4 + i);
      fe.pulses(pn[i] - 1);
      @(posedge sys_clk);
      `CHK(unit_event_flag, 1'h0)
      fe.pulses(1);
      @(posedge sys_clk);
      `CHK(unit_event_flag, 1'h1)
      rd(`OFS_MATCH_LOW);
      `CHK(q, 32'h34 + i)
      rd(`OFS_MATCH_HIGH);
      `CHK(q, 32'h12 + i)
    end
    wr(`OFS_UNIT_CONTROL, 32'h0);
    wr(`OFS_TIMER_LOW, 32'h0);
    sleep_req <= 1'h1;
    wr(`OFS_TIMER_CONFIG, 32'h04);
    repeat (40) @(posedge sys_clk);
    rd(`OFS_TIMER_LOW);
    `CHK(q, 32'h0)
    sleep_req <= 1'h0;
    repeat (20) @(posedge sys_clk);
    rd(`OFS_TIMER_LOW);
    `CHK(q > 32'h0 && q < 32'h10, 1'h1)
    // free-running source: one count per cycle after the write
    wr(`OFS_TIMER_CONFIG, 32'h05);
    wr(`OFS_TIMER_LOW, 32'h0);
    rd(`OFS_TIMER_LOW);
    `CHK(q, 32'h2)
    // external source keeps counting in sleep
    wr(`OFS_TIMER_CONFIG, 32'h0E);
    sleep_req <= 1'h1;
    wr(`OFS_TIMER_LOW, 32'h0);
    wr(`OFS_STATUS, 32'h3);
    wr(`OFS_UNIT_CONTROL, {28'h0, `MODE_CAP_RISE});
    fe.ext_edges(5);
    fe.pulses(1);
    @(posedge sys_clk);
    `CHK(unit_event_flag, 1'h1)
    rd(`OFS_MATCH_LOW);
    `CHK(q, 32'h5)
    // compare stays quiet in sleep, then fires once awake
    wr(`OFS_MATCH_LOW, 32'h08);
    wr(`OFS_UNIT_CONTROL, {28'h0, `MODE_SW_INT});
    wr(`OFS_STATUS, 32'h3);
    fe.ext_edges(5);
    `CHK(unit_event_flag, 1'h0)
    sleep_req <= 1'h0;
    wr(`OFS_MATCH_LOW, 32'h0C);
    fe.ext_edges(5);
    `CHK(unit_event_flag, 1'h1)
    // trigger, then move the match away before the next timer edge
    wr(`OFS_MATCH_LOW, 32'h10);
    wr(`OFS_UNIT_CONTROL, {28'h0, `MODE_SPECIAL});
    fe.ext_edges(1);
    wr(`OFS_MATCH_LOW, 32'h20);
    fe.ext_edges(1);
    rd(`OFS_TIMER_LOW);
    `CHK(q, 32'h11)
    `CHK(fe.n_adc, 2)
    // a true rollover does raise the overflow flag
    wr(`OFS_TIMER_HIGH, 32'hFF);
    wr(`OFS_TIMER_LOW, 32'hFF);
    fe.ext_edges(1);
    `CHK(timer_overflow_flag, 1'h1)
    print_verdict;
  end
endmodule
`default_nettype wire
